// file: ubr_pkg.sv
package ubr_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, low address byte)
  // ----------------------------------------------------------------
  localparam logic [7:0]  UBR_OFF_CTRL   = 8'h00;
  localparam logic [7:0]  UBR_OFF_STATUS = 8'h04;
  localparam logic [7:0]  UBR_OFF_DATA   = 8'h08;
  localparam logic [7:0]  UBR_OFF_BAUD   = 8'h0c;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [8:0]  UBR_CTRL_RST   = 9'h000;
  localparam logic [15:0] UBR_BAUD_RST   = 16'h0068;
  localparam logic [7:0]  UBR_STATUS_RST = 8'h03;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int UBR_CTRL_W      = 9;
  localparam int UBR_STATUS_W    = 8;
  localparam int UBR_BAUD_W      = 16;
  localparam int UBR_DATA_NINTH  = 8;
  localparam int UBR_ST_OVERRUN  = 3;
  localparam int UBR_ST_NOISE    = 4;
  localparam int UBR_ST_FRAMING  = 5;
  localparam int UBR_ST_BREAK    = 6;

  // ----------------------------------------------------------------
  // timing: sample phases of the 16x clock, last phase wraps to 0
  // ----------------------------------------------------------------
  localparam logic [3:0]  UBR_RT_FIRST   = 4'h1;
  localparam logic [3:0]  UBR_RT_LAST    = 4'h0;
  localparam logic [3:0]  UBR_RT_S3      = 4'h3;
  localparam logic [3:0]  UBR_RT_S5      = 4'h5;
  localparam logic [3:0]  UBR_RT_S7      = 4'h7;
  localparam logic [3:0]  UBR_RT_S8      = 4'h8;
  localparam logic [3:0]  UBR_RT_S9      = 4'h9;
  localparam logic [3:0]  UBR_RT_S10     = 4'ha;
  localparam logic [3:0]  UBR_RT_TX_END  = 4'hf;
  localparam logic [3:0]  UBR_FRAME_8    = 4'ha;
  localparam logic [3:0]  UBR_FRAME_9    = 4'hb;
  localparam logic [3:0]  UBR_LAST_8     = 4'h7;
  localparam logic [3:0]  UBR_LAST_9     = 4'h8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic transmit_ninth_bit;
    logic receive_full_irq_enable;
    logic transmission_complete_irq_enable;
    logic transmit_empty_irq_enable;
    logic send_break;
    logic receiver_enable;
    logic transmitter_enable;
    logic transmit_inversion;
    logic char_len_9;
  } ubr_ctrl_t;

  typedef struct packed {
    logic reception_active_flag;
    logic break_flag;
    logic framing_error_flag;
    logic noise_flag;
    logic overrun_flag;
    logic receive_full_flag;
    logic transmission_complete_flag;
    logic transmit_empty_flag;
  } ubr_status_t;

  typedef enum logic [1:0] {
    UBR_TX_IDLE  = 2'b00,
    UBR_TX_SHIFT = 2'b01,
    UBR_TX_BREAK = 2'b11,
    UBR_TX_MARK  = 2'b10
  } ubr_tx_state_t;

  typedef enum logic [1:0] {
    UBR_RX_SEARCH = 2'b00,
    UBR_RX_START  = 2'b01,
    UBR_RX_DATA   = 2'b11,
    UBR_RX_STOP   = 2'b10
  } ubr_rx_state_t;

endpackage

// file: ubr_remote.sv
`timescale 1ns/1ps
module ubr_remote (
  input  wire logic clk,
  output logic      rxd,
  input  wire logic txd
);
  initial rxd = 1'b1;
  // lsb first, 16 clk per bit; bit g gets a one-cycle glitch mid bit
  task automatic send(input logic [10:0] f, input int n, input int g);
    for (int i = 0; i < n; i++)
      for (int j = 0; j < 16; j++)
      begin
        @(posedge clk);
        rxd <= (i == g && j == 8) ? ~f[i] : f[i];
      end
    @(posedge clk);
    rxd <= 1'b1;
    repeat (40) @(posedge clk);
  endtask
  // waits for a start bit, then samples 8 data bits and the stop bit
  task automatic catch(output logic [8:0] d, output int w);
    w = 0;
    do
    begin
      @(posedge clk);
      w++;
    end
    while (txd !== 1'b0);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (16) @(posedge clk);
      d[i] = txd;
    end
  endtask
endmodule

// file: ubr_top.sv
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
// Contract
// RQ1: break is start, eight or nine zero data bits, and zero at stop.
// RQ2: break sets framing, full and break flags, zeroes buffer and ninth bit.
// RQ3: idle character is all ones, length per mode; preamble starts each run.
// RQ4: dropping transmitter enable finishes current character then line idles.
// RQ5: enable cleared then set during transmission queues one idle character.
// RQ6: software re-sets enable before current stop bit leaves, else data lost; here buffered data is kept and sent after the preamble.
// RQ7: inversion flips every transmitted level including idle, break, start, stop.
// RQ8: transmit empty sets when buffer moves to shifter; interrupt when enabled.
// RQ9: complete flag means shifter and buffer empty, no break or idle; irq.
// RQ10: 8- or 9-bit characters; ninth bit holds bit 8 or copies bit 7.
// RQ11: full character moves to read buffer, sets full flag, interrupt when enabled.
// RQ12: line sampled with a clock sixteen times the baud rate.
// RQ13: sample phase resynchronised after start and after data one-to-zero change.
// RQ14: start search wants zero after three ones, then phase counts to 16.
// RQ15: start checked at phases 3,5,7; at most one one passes, one one is noise.
// RQ16: failed start check resets phase counter and restarts the search.
// RQ17: data bit is majority of phases 8,9,10; unequal samples give noise.
// RQ18: start phases 8-10 never cancel start; any one there gives noise.
// RQ19: stop majority zero gives framing error; unequal samples give noise.
// RQ20: framing error flag sets in the same cycle as the full flag.
// RQ21: any valid falling edge inside a character resynchronises sample phase; here only edges inside data bits do, none in the stop bit.
// RQ22: one stop sample outside stop gives noise; more gives framing error.
// RQ23: send break repeats zero characters; after clearing, one more then a one.
// RQ24: noise from any sample group is held and reported with its character.
module ubr_top
  import ubr_pkg::*;
(
  input  logic        clk,
  input  logic        rst_n,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic [31:0] hrdata,
  output logic        hreadyout,
  output logic        hresp,
  input  logic        rxd,
  output logic        txd,
  output logic        tx_irq,
  output logic        rx_irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ubr_ctrl_t             ctrl;
  ubr_status_t           status;
  logic [15:0]           baud_div;
  logic [15:0]           div_cnt;
  logic                  tick;
  logic                  ap_valid;
  logic                  ap_write;
  logic [7:0]            ap_addr;
  logic                  acc;
  logic                  rd_data;
  logic                  wr_ctrl;
  logic                  wr_status;
  logic                  wr_data;
  logic                  wr_baud;
  logic [31:0]           rd_mux;
  ubr_tx_state_t         tx_state;
  ubr_tx_state_t         next_tx_state;
  logic [10:0]           tx_shift;
  logic [10:0]           next_tx_shift;
  logic [3:0]            tx_left;
  logic [3:0]            next_tx_left;
  logic [3:0]            tx_rt;
  logic [8:0]            tx_buf;
  logic                  tx_buf_full;
  logic                  idle_pending;
  logic                  te_q;
  logic                  tx_take;
  logic                  load_idle;
  logic                  load_data;
  logic [3:0]            frame_len;
  logic                  txe;
  logic                  tc;
  ubr_rx_state_t         rx_state;
  logic [3:0]            rt;
  logic [2:0]            hist;
  logic                  s_a;
  logic                  s_b;
  logic [8:0]            rx_shift;
  logic [3:0]            rx_idx;
  logic [3:0]            last_idx;
  logic                  last_bit;
  logic                  noise_acc;
  logic [7:0]            rx_buf;
  logic                  rx_ninth;
  logic                  rxf;
  logic                  overrun;
  logic                  noise;
  logic                  framing;
  logic                  brk;
  logic                  start_fail;
  logic                  resync;
  logic                  bit_done;
  logic                  stop_eval;
  logic                  stop_maj;
  logic                  is_break;
  logic                  char_done;

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic uneq3(input logic [2:0] v);
    uneq3 = (v != 3'b000) && (v != 3'b111);
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  assign acc       = hsel && htrans[1] && hready;
  assign rd_data   = acc && !hwrite && (haddr[7:0] == UBR_OFF_DATA);
  assign wr_ctrl   = ap_valid && ap_write && (ap_addr == UBR_OFF_CTRL);
  assign wr_status = ap_valid && ap_write && (ap_addr == UBR_OFF_STATUS);
  assign wr_data   = ap_valid && ap_write && (ap_addr == UBR_OFF_DATA);
  assign wr_baud   = ap_valid && ap_write && (ap_addr == UBR_OFF_BAUD);

  assign status = '{reception_active_flag:      (rx_state != UBR_RX_SEARCH),
                    break_flag:                 brk,
                    framing_error_flag:         framing,
                    noise_flag:                 noise,
                    overrun_flag:               overrun,
                    receive_full_flag:          rxf,
                    transmission_complete_flag: tc,
                    transmit_empty_flag:        txe};

  always_comb
  begin
    case (haddr[7:0])
      UBR_OFF_CTRL:   rd_mux = {23'h000000, ctrl};
      UBR_OFF_STATUS: rd_mux = {24'h000000, status};
      UBR_OFF_DATA:   rd_mux = {23'h000000, rx_ninth, rx_buf};
      UBR_OFF_BAUD:   rd_mux = {16'h0000, baud_div};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ap_valid  <= 1'b0;
      ap_write  <= 1'b0;
      ap_addr   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      ap_valid  <= acc;
      ap_write  <= hwrite;
      ap_addr   <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc && !hwrite)
        hrdata <= rd_mux;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl     <= ubr_ctrl_t'(UBR_CTRL_RST);
      baud_div <= UBR_BAUD_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= ubr_ctrl_t'(hwdata[UBR_CTRL_W-1:0]);
      if (wr_baud)
        baud_div <= hwdata[UBR_BAUD_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // 16x sample enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end
    else if (div_cnt >= baud_div)
    begin
      div_cnt <= 16'h0000;
      tick    <= 1'b1;                                         // RQ12
    end
    else
    begin
      div_cnt <= div_cnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  assign frame_len = ctrl.char_len_9 ? UBR_FRAME_9 : UBR_FRAME_8;
  assign tx_take   = (tx_state == UBR_TX_IDLE) ||
                     (tick && (tx_rt == UBR_RT_TX_END) && (tx_left == 4'h1));

  // choice of the next character once the shifter frees up
  always_comb
  begin
    next_tx_state = UBR_TX_IDLE;
    next_tx_shift = 11'h7ff;
    next_tx_left  = frame_len;
    load_idle     = 1'b0;
    load_data     = 1'b0;
    if (!ctrl.transmitter_enable || !te_q)
      next_tx_state = UBR_TX_IDLE;                             // RQ4
    else if (idle_pending)
    begin
      next_tx_state = UBR_TX_SHIFT;                            // RQ3 RQ5
      load_idle     = 1'b1;
    end
    else if (ctrl.send_break)
    begin
      next_tx_state = UBR_TX_BREAK;                            // RQ23
      next_tx_shift = 11'h000;
    end
    else if (tx_state == UBR_TX_BREAK)
    begin
      next_tx_state = UBR_TX_MARK;                             // RQ23
      next_tx_left  = 4'h1;
    end
    else if (tx_buf_full)
    begin
      next_tx_state = UBR_TX_SHIFT;
      load_data     = 1'b1;
      if (ctrl.char_len_9)
        next_tx_shift = {1'b1, tx_buf, 1'b0};
      else
        next_tx_shift = {2'b11, tx_buf[7:0], 1'b0};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_state <= UBR_TX_IDLE;
      tx_shift <= 11'h7ff;
      tx_left  <= 4'h0;
      tx_rt    <= 4'h0;
    end
    else if (tx_take)
    begin
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      tx_left  <= next_tx_left;
      tx_rt    <= 4'h0;
    end
    else if (tick)
    begin
      tx_rt <= tx_rt + 4'h1;
      if (tx_rt == UBR_RT_TX_END)
      begin
        tx_shift <= {1'b1, tx_shift[10:1]};
        tx_left  <= tx_left - 4'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      te_q         <= 1'b0;
      idle_pending <= 1'b0;
    end
    else
    begin
      te_q <= ctrl.transmitter_enable;
      if (ctrl.transmitter_enable && !te_q)
        idle_pending <= 1'b1;                                  // RQ3 RQ5
      else if (tx_take && load_idle)
        idle_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_buf      <= 9'h000;
      tx_buf_full <= 1'b0;
      txe         <= 1'b1;
    end
    else if (tx_take && load_data)
    begin
      tx_buf_full <= 1'b0;
      txe         <= 1'b1;                                     // RQ8
    end
    else if (wr_data)
    begin
      tx_buf      <= {ctrl.transmit_ninth_bit, hwdata[7:0]};
      tx_buf_full <= 1'b1;
      txe         <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tc     <= 1'b1;
      txd    <= 1'b1;
      tx_irq <= 1'b0;
    end
    else
    begin
      tc     <= (tx_state == UBR_TX_IDLE) && !tx_buf_full && !idle_pending &&
                !ctrl.send_break;                              // RQ9
      txd    <= ((tx_state == UBR_TX_IDLE) ? 1'b1 : tx_shift[0]) ^
                ctrl.transmit_inversion;                       // RQ7
      tx_irq <= (txe && ctrl.transmit_empty_irq_enable) ||
                (tc && ctrl.transmission_complete_irq_enable); // RQ8 RQ9
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  assign last_idx   = ctrl.char_len_9 ? UBR_LAST_9 : UBR_LAST_8;
  assign start_fail = (rx_state == UBR_RX_START) && tick && (rt == UBR_RT_S7) &&
                      !((s_a + s_b + rxd) <= 2'd1);           // RQ15
  assign resync     = (rx_state == UBR_RX_DATA) && tick && last_bit &&
                      hist[0] && !rxd &&
                      ((rt < UBR_RT_S8) || (rt > UBR_RT_S10)); // RQ13 RQ21
  assign bit_done   = tick && ((rt == UBR_RT_LAST) ||
                      (resync && (rt > UBR_RT_S10)));
  assign stop_eval  = (rx_state == UBR_RX_STOP) && tick && (rt == UBR_RT_S10);
  assign stop_maj   = maj3({s_a, s_b, rxd});
  assign is_break   = !stop_maj &&
                      (ctrl.char_len_9 ? (rx_shift == 9'h000)
                                       : (rx_shift[7:0] == 8'h00)); // RQ1
  assign char_done  = stop_eval && !rxf;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hist <= 3'b000;
    else if (start_fail)
      hist <= 3'b000;                                          // RQ16
    else if (tick)
      hist <= {hist[1:0], rxd};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_state <= UBR_RX_SEARCH;
      rt       <= 4'h0;
      rx_idx   <= 4'h0;
    end
    else if (!ctrl.receiver_enable)
      rx_state <= UBR_RX_SEARCH;
    else if (tick)
    begin
      rt <= resync ? UBR_RT_FIRST : rt + 4'h1;                 // RQ13 RQ21
      case (rx_state)
        UBR_RX_SEARCH:
          if ((hist == 3'b111) && !rxd)
          begin
            rx_state <= UBR_RX_START;                          // RQ14
            rt       <= UBR_RT_FIRST;
          end
        UBR_RX_START:
          if (start_fail)
          begin
            rx_state <= UBR_RX_SEARCH;                         // RQ16
            rt       <= 4'h0;
          end
          else if (rt == UBR_RT_LAST)
          begin
            rx_state <= UBR_RX_DATA;
            rx_idx   <= 4'h0;
          end
        UBR_RX_DATA:
          if (bit_done)
          begin
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == last_idx)
              rx_state <= UBR_RX_STOP;
          end
        UBR_RX_STOP:
          if (rt == UBR_RT_S10)
            rx_state <= UBR_RX_SEARCH;
        default:
          rx_state <= UBR_RX_SEARCH;
      endcase
    end
  end

  // sample groups: two samples held, third taken live
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_a       <= 1'b0;
      s_b       <= 1'b0;
      rx_shift  <= 9'h000;
      last_bit  <= 1'b0;
      noise_acc <= 1'b0;
    end
    else if (tick)
    begin
      if ((rt == UBR_RT_S3) || (rt == UBR_RT_S8))
        s_a <= rxd;
      if ((rt == UBR_RT_S5) || (rt == UBR_RT_S9))
        s_b <= rxd;
      case (rx_state)
        UBR_RX_SEARCH:
          if ((hist == 3'b111) && !rxd)
          begin
            noise_acc <= 1'b0;
            rx_shift  <= 9'h000;
            last_bit  <= 1'b0;
          end
        UBR_RX_START:
          if ((rt == UBR_RT_S7) && ((s_a + s_b + rxd) == 2'd1))
            noise_acc <= 1'b1;                                 // RQ15
          else if ((rt == UBR_RT_S10) && (s_a || s_b || rxd))
            noise_acc <= 1'b1;                                 // RQ18
        UBR_RX_DATA:
          if (rt == UBR_RT_S10)
          begin
            rx_shift[rx_idx] <= maj3({s_a, s_b, rxd});         // RQ17
            last_bit         <= maj3({s_a, s_b, rxd});
            if (uneq3({s_a, s_b, rxd}))
              noise_acc <= 1'b1;                               // RQ17 RQ24
          end
        default:
          ;
      endcase
    end
  end

  // read buffer, received ninth bit and receive flags
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_buf   <= 8'h00;
      rx_ninth <= 1'b0;
    end
    else if (char_done)
    begin
      rx_buf   <= is_break ? 8'h00 : rx_shift[7:0];            // RQ11 RQ2
      rx_ninth <= is_break ? 1'b0 :
                  (ctrl.char_len_9 ? rx_shift[8] : rx_shift[7]); // RQ10 RQ2
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rxf     <= 1'b0;
      overrun <= 1'b0;
      noise   <= 1'b0;
      framing <= 1'b0;
      brk     <= 1'b0;
      rx_irq  <= 1'b0;
    end
    else
    begin
      rx_irq <= rxf && ctrl.receive_full_irq_enable;           // RQ11
      if (char_done)
        rxf <= 1'b1;                                           // RQ11
      else if (rd_data)
        rxf <= 1'b0;
      if (stop_eval && rxf)
        overrun <= 1'b1;
      else if (wr_status && hwdata[UBR_ST_OVERRUN])
        overrun <= 1'b0;
      if (char_done && (noise_acc || uneq3({s_a, s_b, rxd})))
        noise <= 1'b1;                                         // RQ19 RQ22 RQ24
      else if (wr_status && hwdata[UBR_ST_NOISE])
        noise <= 1'b0;
      if (char_done && !stop_maj)
        framing <= 1'b1;                                       // RQ19 RQ20 RQ22
      else if (wr_status && hwdata[UBR_ST_FRAMING])
        framing <= 1'b0;
      if (char_done && is_break)
        brk <= 1'b1;                                           // RQ2
      else if (wr_status && hwdata[UBR_ST_BREAK])
        brk <= 1'b0;
    end
  end

endmodule

// file: ubr_top_monitor.sv
`timescale 1ns/1ps
module ubr_top_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        txd,
  input wire logic        tx_irq,
  input wire logic        rx_irq
);
  logic       taken;
  logic [3:0] since;
  logic [4:0] run;
  logic       txd_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign taken = hsel && htrans[1] && hready;
  // cycles since the last bus access, saturating
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      since <= 4'hf;
    else if (taken)
      since <= 4'h0;
    else if (since != 4'hf)
      since <= since + 4'h1;
  end
  // cycles the serial output has held its level
  always_ff @(posedge clk)
  begin
    txd_q <= txd;
    if (!rst_n || txd != txd_q)
      run <= 5'h00;
    else if (run != 5'h1f)
      run <= run + 5'h01;
  end
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_hold; !(taken && !hwrite) |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("hrdata moved without read");
  property p_unmap; taken && !hwrite && haddr[7:4] != 4'h0 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_idle; $rose(rst_n) |-> txd && !tx_irq && !rx_irq; endproperty
  a_idle: assert property (p_idle) else $error("outputs not idle at reset");
  property p_bit; txd != txd_q && since > 4'h8 |-> run >= 5'h0f; endproperty
  a_bit: assert property (p_bit) else $error("serial bit shorter than 16 ticks");
  property p_txf; $fell(tx_irq) |-> since <= 4'h8; endproperty
  a_txf: assert property (p_txf) else $error("tx request dropped on its own");
  property p_rxf; $fell(rx_irq) |-> since <= 4'h8; endproperty
  a_rxf: assert property (p_rxf) else $error("rx request dropped on its own");
endmodule
bind ubr_top ubr_top_monitor u_mon (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq));

// file: ubr_top_tb_top.sv
`timescale 1ns/1ps
module ubr_top_tb_top;
  import ubr_pkg::*;
  localparam logic [31:0] L9 = 32'h01, INV = 32'h02, TE = 32'h04;
  localparam logic [31:0] RE = 32'h08, TEI = 32'h20, RI = 32'h80;
  localparam logic [31:0] SEND_BREAK = 32'h10;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rv;
  logic [8:0]  fr;
  logic        hreadyout, hresp, rxd, txd, tx_irq, rx_irq;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          wt;
  always #2.5 clk = ~clk;
  ubr_top uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd), .tx_irq(tx_irq),
    .rx_irq(rx_irq));
  ubr_remote peer (.clk(clk), .rxd(rxd), .txd(txd));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  // one single transfer; read data lands in rv
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      conclude();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b0, UBR_OFF_STATUS, 32'h0);
    cmp(rv, {24'h0, UBR_STATUS_RST});
    acc(1'b0, UBR_OFF_BAUD, 32'h0);
    cmp(rv, {16'h0, UBR_BAUD_RST});
    acc(1'b0, 8'h10, 32'h0);
    cmp(rv, 32'h0);
    acc(1'b1, UBR_OFF_BAUD, 32'h0);
    repeat (120) @(posedge clk);
    $display("test reset done");
    acc(1'b1, UBR_OFF_CTRL, TE | RE | TEI);
    acc(1'b1, UBR_OFF_DATA, 32'ha5);
    fork
      peer.catch(fr, wt);
      begin
        do @(posedge clk); while (txd !== 1'b0);
        repeat (20) @(posedge clk);
        acc(1'b1, UBR_OFF_CTRL, RE | TEI);
      end
    join
    cmp(wt >= 150 && wt <= 165, 32'h1);
    cmp(fr, 9'h1a5);
    repeat (64) @(posedge clk);
    cmp(txd, 1'b1);
    cmp(tx_irq, 1'b1);
    acc(1'b0, UBR_OFF_STATUS, 32'h0);
    cmp(rv & 32'h3, 32'h3);
    acc(1'b1, UBR_OFF_CTRL, INV | RE);
    repeat (4) @(posedge clk);
    cmp(txd, 1'b0);
    // enable toggled just after the byte moves to the shifter queues one idle
    acc(1'b1, UBR_OFF_CTRL, TE | RE);
    acc(1'b1, UBR_OFF_DATA, 32'h3c);
    fork
      peer.catch(fr, wt);
      begin
        do @(posedge clk); while (txd !== 1'b0);
        acc(1'b1, UBR_OFF_CTRL, RE);
        acc(1'b1, UBR_OFF_CTRL, TE | RE);
        acc(1'b1, UBR_OFF_DATA, 32'hc3);
      end
    join
    cmp(fr, 9'h13c);
    // queued idle: ten idle bits of 16 cycles before the next start bit
    peer.catch(fr, wt);
    cmp(wt >= 160 && wt <= 175, 32'h1);
    cmp(fr, 9'h1c3);
    $display("test idle queue done");
    acc(1'b1, UBR_OFF_CTRL, TE | RE | SEND_BREAK);
    peer.catch(fr, wt);
    acc(1'b1, UBR_OFF_CTRL, TE | RE);
    acc(1'b0, UBR_OFF_STATUS, 32'h0);
    cmp(rv & 32'h3, 32'h1);
    cmp(fr, 32'h0);
    repeat (40) @(posedge clk);
    cmp(txd, 1'b1);
    acc(1'b0, UBR_OFF_STATUS, 32'h0);
    cmp(rv & 32'h3, 32'h3);
    $display("test break send done");
    $display("test transmit done");
    acc(1'b1, UBR_OFF_CTRL, RE | RI);
    peer.send(11'h346, 10, 99);
    cmp(rx_irq, 1'b1);
    acc(1'b0, UBR_OFF_STATUS, 32'h0);
    cmp(rv & 32'h7c, 32'h04);
    acc(1'b0, UBR_OFF_DATA, 32'h0);
    cmp(rv & 32'h1ff, 32'h1a3);
    repeat (4) @(posedge clk);
    cmp(rx_irq, 1'b0);
    acc(1'b1, UBR_OFF_CTRL, RE | L9);
    peer.send(11'h546, 11, 99);
    acc(1'b0, UBR_OFF_DATA, 32'h0);
    cmp(rv & 32'h1ff, 32'h0a3);
    acc(1'b1, UBR_OFF_CTRL, RE);
    $display("test receive done");
    peer.send(11'h000, 10, 99);
    acc(1'b0, UBR_OFF_STATUS, 32'h0);
    cmp(rv & 32'h7c, 32'h64);
    acc(1'b0, UBR_OFF_DATA, 32'h0);
    cmp(rv & 32'h1ff, 32'h0);
    acc(1'b1, UBR_OFF_STATUS, 32'h78);
    $display("test break done");
    peer.send(11'h7ff, 1, 0);
    acc(1'b0, UBR_OFF_STATUS, 32'h0);
    cmp(rv & 32'h7c, 32'h0);
    peer.send(11'h0aa, 10, 3);
    acc(1'b0, UBR_OFF_STATUS, 32'h0);
    cmp(rv & 32'h7c, 32'h34);
    acc(1'b0, UBR_OFF_DATA, 32'h0);
    cmp(rv & 32'h1ff, 32'h055);
    $display("test errors done");
    conclude();
  end
endmodule
